// ==== verilog/sfife_top.sv ====
// Purpose: instruction front end of a serial flash, pins sampled by the core clock
// Assumes: host drives select, clock and serial input; array and sequencer sit outside
// Notes:   program/erase cycles end when software writes the done bit over apb
// Functional notes
// RL1 - select falling starts instruction; first byte opcode
// RL2 - input sampled on clock rise, msb first
// RL3 - write/program/erase aborted unless byte-aligned deselect
// RL4 - reads end cleanly on any deselect
// RL5 - while busy only status read accepted
// RL6 - 06h sets write enable latch
// RL7 - 04h, reset and cycle completion clear latch
// RL8 - 05h streams status repeatedly on falling edges
// RL9 - 01h writes status only with latch set
// RL10 - status write touches bits 7,5,4,3,2 only
// RL11 - nonvolatile status write runs timed busy cycle
// RL12 - 50h prefix: immediate update, never busy
// RL13 - lock bit plus low protect rejects writes
// RL14 - 03h takes 24-bit address, returns data
// RL15 - read address increments, streams whole array
// RL16 - read while busy ignored, cycle untouched
// RL17 - 3Bh dual output, even bits on io0
// RL18 - B9h powers down; ABh releases, returns id
// RL19 - 90h: three bytes, then maker, device codes
// RL20 - 9Fh returns maker, type, capacity msb first
// RL21 - 0Bh inserts eight ignored dummy clocks
// RL22 - 02h programs bytes, wrapping inside page
// RL23 - 20h/D8h/52h erase addressed region with latch
// RL24 - C7h/60h erase whole array with latch
// RL25 - unknown opcode ignored, output stays off
//
// Added by the designer: the register addresses and register access over APB.
module sfife_top #(
  parameter int         TW_NS     = 5000000,
  parameter logic [7:0] MFR_ID    = 8'hA5,  // arbitrary
  parameter logic [7:0] MEM_TYPE  = 8'h22,  // arbitrary
  parameter logic [7:0] CAPACITY  = 8'h33,  // arbitrary
  parameter logic [7:0] DEV_ID    = 8'h3C   // arbitrary
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_serial_io0,
  input  wire logic        i_wp_n,
  output logic             o_serial_out,
  output logic             o_serial_out_oe,
  output logic             o_serial_io0,
  output logic             o_serial_io0_oe,
  output logic [23:0]      o_arr_addr,
  input  wire logic [7:0]  i_arr_data,
  output logic             o_pgm_vld,
  output logic [7:0]       o_pgm_data,
  output logic [23:0]      o_pgm_addr,
  output logic             o_op_vld,
  output logic [7:0]       o_op_code,
  output logic [23:0]      o_op_addr,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr
);
  localparam int          TW_CYC  = TW_NS / sfife_pkg::CLK_PERIOD_NS;
  localparam logic [23:0] TW_LOAD = 24'(TW_CYC - 1);

  sfife_pkg::sfife_state_t q, d;
  logic       sck_rise, sck_fall, cs_rise, cs_fall, spi_live, byte_done, out_fall;
  logic [7:0] byte_in, stat;

  assign sck_rise  = q.sck_s2 & ~q.sck_d;
  assign sck_fall  = ~q.sck_s2 & q.sck_d;
  assign cs_rise   = q.cs_s2 & ~q.cs_d;
  assign cs_fall   = ~q.cs_s2 & q.cs_d;
  assign spi_live  = ~cs_rise & ~cs_fall & (q.st != sfife_pkg::S_IDLE);
  assign byte_done = spi_live & sck_rise & (q.bitcnt == sfife_pkg::LAST_BIT);
  assign out_fall  = spi_live & sck_fall & (q.st == sfife_pkg::S_OUT);
  assign byte_in   = {q.shin[6:0], q.io0_s2};
  assign stat      = {q.status_lock_bit, 1'b0, q.bp, q.write_enable_latch, q.busy};

  function automatic logic [7:0] src_byte(input logic [7:0] op, input logic [1:0] idx,
                                          input logic [7:0] st, input logic [7:0] arr);
    unique case (op)
      sfife_pkg::OP_RDSR: src_byte = st;
      sfife_pkg::OP_RES:  src_byte = DEV_ID;
      sfife_pkg::OP_MID:  src_byte = idx[0] ? DEV_ID : MFR_ID;
      sfife_pkg::OP_JID:  src_byte = (idx == 2'h0) ? MFR_ID : ((idx == 2'h1) ? MEM_TYPE : CAPACITY);
      default:            src_byte = arr;
    endcase
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == sfife_pkg::OP_READ) | (op == sfife_pkg::OP_FAST) | (op == sfife_pkg::OP_DUAL);
  endfunction

  always_comb begin
    logic [7:0]  ob;
    logic [23:0] na;
    logic        dual;
    ob   = q.osh;
    na   = {q.addr[15:0], byte_in};
    dual = (q.opcode == sfife_pkg::OP_DUAL);
    d    = q;
    d.pgm_vld = 1'b0;
    d.op_vld  = 1'b0;
    d.pready  = 1'b0;
    // two flops on select, clock, io0 and wp before any logic looks at them
    d.cs_s1  = i_cs_n;
    d.cs_s2  = q.cs_s1;
    d.cs_d   = q.cs_s2;
    d.sck_s1 = i_sck;
    d.sck_s2 = q.sck_s1;
    d.sck_d  = q.sck_s2;
    d.io0_s1 = i_serial_io0;
    d.io0_s2 = q.io0_s1;
    d.wp_s1  = i_wp_n;
    d.wp_s2  = q.wp_s1;

    if (q.nv_pend) begin
      if (q.timer == 24'h000000) begin
        d.nv_pend = 1'b0;
        d.busy    = 1'b0;  // RL11
        d.write_enable_latch     = 1'b0;  // RL7
      end else begin
        d.timer = q.timer - 24'h000001;
      end
    end

    // apb: zero-wait slave, data prepared in the setup cycle
    if (i_psel && !i_penable) begin
      d.pready  = 1'b1;
      d.pslverr = 1'b0;
      d.prdata  = 32'h00000000;
      unique case (i_paddr)
        sfife_pkg::REG_STATUS: d.prdata = {21'h0, q.nv_pend, q.dpd, q.vol, stat};
        sfife_pkg::REG_CTRL:   d.prdata = 32'h00000000;
        sfife_pkg::REG_OPINFO: d.prdata = {q.op_code, q.op_addr};
        default:               d.pslverr = 1'b1;
      endcase
    end
    if (i_psel && i_penable && q.pready && i_pwrite && !q.pslverr && i_paddr == sfife_pkg::REG_CTRL
        && i_pwdata[sfife_pkg::CTRL_DONE] && q.busy && !q.nv_pend) begin
      d.busy = 1'b0;
      d.write_enable_latch  = 1'b0;  // RL7
    end

    if (cs_rise) begin
      d.st     = sfife_pkg::S_IDLE;  // RL4
      d.so_oe  = 1'b0;
      d.io0_oe = 1'b0;
      // opcode still holds the previous frame's until this one decodes its own
      if (q.opcode == sfife_pkg::OP_RES && q.st != sfife_pkg::S_IGN && q.st != sfife_pkg::S_OPC) begin
        d.dpd = 1'b0;  // RL18
      end
      if (q.bitcnt == 3'h0) begin  // RL3
        if (q.st == sfife_pkg::S_END) begin
          unique case (q.opcode)
            sfife_pkg::OP_WREN:  d.write_enable_latch = 1'b1;  // RL6
            sfife_pkg::OP_WRDI:  d.write_enable_latch = 1'b0;  // RL7
            sfife_pkg::OP_VWREN: d.vol = 1'b1;
            sfife_pkg::OP_DPD:   d.dpd = 1'b1;  // RL18
            sfife_pkg::OP_WRSR: begin
              d.status_lock_bit = q.wsr_data[7];  // RL10
              d.bp  = q.wsr_data[5:2];
              if (q.vol) begin
                d.vol = 1'b0;  // RL12
              end else begin
                d.busy    = 1'b1;  // RL11
                d.nv_pend = 1'b1;
                d.timer   = TW_LOAD;
              end
            end
            default: begin
              d.busy   = 1'b1;  // RL23 RL24
              d.op_vld = 1'b1;
            end
          endcase
        end else if (q.st == sfife_pkg::S_PGM && q.got) begin
          d.busy   = 1'b1;  // RL22
          d.op_vld = 1'b1;
        end
      end
    end else if (cs_fall) begin
      d.st     = sfife_pkg::S_OPC;  // RL1
      d.bitcnt = 3'h0;
    end else if (q.st != sfife_pkg::S_IDLE) begin
      if (sck_rise) begin
        d.shin   = byte_in;  // RL2
        d.bitcnt = q.bitcnt + 3'h1;
      end
      if (byte_done) begin
        unique case (q.st)
          sfife_pkg::S_OPC: begin
            d.opcode = byte_in;
            d.bcnt   = 3'h0;
            d.idx    = 2'h0;
            d.ocnt   = 3'h0;
            d.got    = 1'b0;
            d.op_code = byte_in;
            d.op_addr = 24'h000000;
            if (byte_in != sfife_pkg::OP_WRSR && byte_in != sfife_pkg::OP_VWREN) d.vol = 1'b0;
            if ((q.dpd && byte_in != sfife_pkg::OP_RES) || (q.busy && byte_in != sfife_pkg::OP_RDSR)) begin
              d.st = sfife_pkg::S_IGN;  // RL5 RL16
            end else begin
              unique case (byte_in)
                sfife_pkg::OP_WREN, sfife_pkg::OP_WRDI, sfife_pkg::OP_VWREN, sfife_pkg::OP_DPD:
                  d.st = sfife_pkg::S_END;
                sfife_pkg::OP_CE1, sfife_pkg::OP_CE2:
                  d.st = q.write_enable_latch ? sfife_pkg::S_END : sfife_pkg::S_IGN;  // RL24
                sfife_pkg::OP_RDSR, sfife_pkg::OP_JID:
                  d.st = sfife_pkg::S_OUT;  // RL8 RL20
                sfife_pkg::OP_WRSR:
                  d.st = ((q.write_enable_latch || q.vol) && !(q.status_lock_bit && !q.wp_s2)) ? sfife_pkg::S_WSR
                                                                    : sfife_pkg::S_IGN;  // RL9 RL13
                sfife_pkg::OP_READ, sfife_pkg::OP_MID, sfife_pkg::OP_RES: begin
                  d.st    = sfife_pkg::S_ADDR;  // RL14 RL19 RL18
                  d.bneed = sfife_pkg::ADDR_BYTES;
                end
                sfife_pkg::OP_FAST, sfife_pkg::OP_DUAL: begin
                  d.st    = sfife_pkg::S_ADDR;  // RL21 RL17
                  d.bneed = sfife_pkg::FAST_BYTES;
                end
                sfife_pkg::OP_PP, sfife_pkg::OP_SE, sfife_pkg::OP_BE, sfife_pkg::OP_HBE: begin
                  d.st    = q.write_enable_latch ? sfife_pkg::S_ADDR : sfife_pkg::S_IGN;  // RL22 RL23
                  d.bneed = sfife_pkg::ADDR_BYTES;
                end
                default: d.st = sfife_pkg::S_IGN;  // RL25
              endcase
            end
          end
          sfife_pkg::S_ADDR: begin
            if (q.bcnt < sfife_pkg::ADDR_BYTES) d.addr = na;
            d.bcnt = q.bcnt + 3'h1;
            if (q.bcnt + 3'h1 == q.bneed) begin
              if (q.opcode == sfife_pkg::OP_PP) begin
                d.st      = sfife_pkg::S_PGM;
                d.op_addr = na;
              end else if (q.opcode == sfife_pkg::OP_SE || q.opcode == sfife_pkg::OP_BE
                           || q.opcode == sfife_pkg::OP_HBE) begin
                d.st      = sfife_pkg::S_END;
                d.op_addr = na;
              end else begin
                d.st = sfife_pkg::S_OUT;
              end
            end
          end
          sfife_pkg::S_WSR: begin
            d.wsr_data = byte_in;
            d.st       = sfife_pkg::S_END;
          end
          sfife_pkg::S_PGM: begin
            d.pgm_vld   = 1'b1;
            d.pgm_data  = byte_in;
            d.pgm_addr  = q.addr;
            d.addr[7:0] = q.addr[7:0] + 8'h01;  // RL22
            d.got       = 1'b1;
          end
          default: d.st = q.st;
        endcase
      end
      if (out_fall) begin
        if (q.ocnt == 3'h0) begin
          ob = src_byte(q.opcode, q.idx, stat, i_arr_data);  // RL8 RL18 RL19 RL20
          if (is_read(q.opcode)) d.addr = q.addr + 24'h000001;  // RL15
          d.idx = (q.opcode == sfife_pkg::OP_JID && q.idx == sfife_pkg::JID_LAST) ? 2'h0 : q.idx + 2'h1;
        end
        d.so    = ob[7];
        d.so_oe = 1'b1;
        if (dual) begin
          d.io0_o  = ob[6];  // RL17
          d.io0_oe = 1'b1;
          d.osh    = {ob[5:0], 2'h0};
          d.ocnt   = (q.ocnt == sfife_pkg::LAST_DUAL) ? 3'h0 : q.ocnt + 3'h1;
        end else begin
          d.osh  = {ob[6:0], 1'b0};
          d.ocnt = q.ocnt + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q        <= '0;
      q.cs_s1  <= 1'b1;
      q.cs_s2  <= 1'b1;
      q.cs_d   <= 1'b1;
      q.wp_s1  <= 1'b1;
      q.wp_s2  <= 1'b1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_serial_out    = q.so;
  assign o_serial_out_oe = q.so_oe;
  assign o_serial_io0    = q.io0_o;
  assign o_serial_io0_oe = q.io0_oe;
  assign o_arr_addr      = q.addr;
  assign o_pgm_vld       = q.pgm_vld;
  assign o_pgm_data      = q.pgm_data;
  assign o_pgm_addr      = q.pgm_addr;
  assign o_op_vld        = q.op_vld;
  assign o_op_code       = q.op_code;
  assign o_op_addr       = q.op_addr;
  assign o_pready        = q.pready;
  assign o_prdata        = q.prdata;
  assign o_pslverr       = q.pslverr;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // commit point of every write-type instruction but page program: select rising in S_END on a byte edge
  sequence s_end_at(logic [7:0] op);
    i_ce && cs_rise && q.st == sfife_pkg::S_END && q.opcode == op && q.bitcnt == 3'h0;
  endsequence
  sequence s_nv_commit;
    s_end_at(sfife_pkg::OP_WRSR) ##0 !q.vol;
  endsequence

  a_wren_sets_wel:   assert property (s_end_at(sfife_pkg::OP_WREN) |=> q.write_enable_latch)  // RL6
    else $error("write enable did not set latch");
  a_wrdi_clears_wel: assert property (s_end_at(sfife_pkg::OP_WRDI) |=> !q.write_enable_latch)  // RL7
    else $error("write disable did not clear latch");
  a_busy_ignores:    assert property (i_ce && byte_done && q.st == sfife_pkg::S_OPC && q.busy  // RL5
                                      && byte_in != sfife_pkg::OP_RDSR |=> q.st == sfife_pkg::S_IGN)
    else $error("instruction taken while busy");
  a_partial_abort:   assert property (i_ce && cs_rise && q.bitcnt != 3'h0 && !q.busy  // RL3
                                      |=> !q.busy && !q.op_vld)
    else $error("unaligned deselect started a cycle");
  a_read_ends:       assert property (i_ce && cs_rise && q.st == sfife_pkg::S_OUT  // RL4
                                      |=> q.st == sfife_pkg::S_IDLE && !o_serial_out_oe && !o_serial_io0_oe)
    else $error("read did not end on deselect");
  a_ign_quiet:       assert property (q.st == sfife_pkg::S_IGN |-> !o_serial_out_oe && !o_serial_io0_oe)  // RL25
    else $error("output driven for ignored opcode");
  a_nv_busy_cycle:   assert property (s_nv_commit |=> q.busy && q.nv_pend ##1 q.busy)  // RL11
    else $error("status write did not start busy cycle");
  a_vol_no_busy:     assert property (s_end_at(sfife_pkg::OP_WRSR) ##0 q.vol  // RL12
                                      |=> !q.busy && q.bp == $past(q.wsr_data[5:2]) && q.status_lock_bit == $past(q.wsr_data[7]))
    else $error("volatile status write wrong");
  a_wsr_lock:        assert property (i_ce && byte_done && q.st == sfife_pkg::S_OPC && !q.busy && !q.dpd  // RL13
                                      && byte_in == sfife_pkg::OP_WRSR && q.status_lock_bit && !q.wp_s2
                                      |=> q.st == sfife_pkg::S_IGN)
    else $error("locked status write accepted");
  a_rdsr_msb:        assert property (i_ce && out_fall && q.opcode == sfife_pkg::OP_RDSR && q.ocnt == 3'h0  // RL8
                                      |=> o_serial_out == $past(stat[7]) && o_serial_out_oe)
    else $error("status msb not driven");
  a_read_incr:       assert property (i_ce && out_fall && q.opcode == sfife_pkg::OP_READ && q.ocnt == 3'h0  // RL15
                                      |=> q.addr == $past(q.addr) + 24'h000001)
    else $error("read address not advanced");
  a_dual_pins:       assert property (i_ce && out_fall && q.opcode == sfife_pkg::OP_DUAL  // RL17
                                      |=> o_serial_io0_oe && o_serial_out_oe)
    else $error("dual output pins not both driven");
  // wrap touches only the low address byte, so a long burst never leaves its page
  a_pgm_in_page:     assert property (i_ce && byte_done && q.st == sfife_pkg::S_PGM  // RL22
                                      |=> o_pgm_vld && o_pgm_addr == $past(q.addr)
                                          && q.addr[23:8] == $past(q.addr[23:8]))
    else $error("program byte left its page");
  a_dpd_ignores:     assert property (i_ce && byte_done && q.st == sfife_pkg::S_OPC && q.dpd  // RL18
                                      && byte_in != sfife_pkg::OP_RES |=> q.st == sfife_pkg::S_IGN)
    else $error("instruction taken while powered down");
  a_wsr_needs_wel:   assert property (i_ce && byte_done && q.st == sfife_pkg::S_OPC && !q.busy && !q.dpd  // RL9
                                      && byte_in == sfife_pkg::OP_WRSR && !q.write_enable_latch && !q.vol
                                      |=> q.st == sfife_pkg::S_IGN)
    else $error("status write taken without latch");
  a_nv_done:         assert property (i_ce && q.nv_pend && q.timer == 24'h000000  // RL11
                                      |=> !q.busy && !q.write_enable_latch && !q.nv_pend)
    else $error("status write cycle did not end cleanly");
  a_se_commit:       assert property (s_end_at(sfife_pkg::OP_SE)  // RL23
                                      |=> q.busy && o_op_vld && o_op_code == sfife_pkg::OP_SE)
    else $error("sector erase not committed");
  a_ce_commit:       assert property (s_end_at(sfife_pkg::OP_CE2)  // RL24
                                      |=> q.busy && o_op_vld && o_op_code == sfife_pkg::OP_CE2)
    else $error("chip erase not committed");
endmodule

// ==== verilog/sfife_pkg.sv ====
// Purpose: shared constants and types for the serial flash instruction front end
// Assumes: 100 MHz core clock, serial pins sampled by that clock
// Notes:   apb offsets are byte addresses of 32-bit words
package sfife_pkg;
  localparam int          CLK_PERIOD_NS = 10;
  localparam logic [7:0]  OP_WREN       = 8'h06;
  localparam logic [7:0]  OP_WRDI       = 8'h04;
  localparam logic [7:0]  OP_RDSR       = 8'h05;
  localparam logic [7:0]  OP_WRSR       = 8'h01;
  localparam logic [7:0]  OP_VWREN      = 8'h50;
  localparam logic [7:0]  OP_READ       = 8'h03;
  localparam logic [7:0]  OP_FAST       = 8'h0B;
  localparam logic [7:0]  OP_DUAL       = 8'h3B;
  localparam logic [7:0]  OP_PP         = 8'h02;
  localparam logic [7:0]  OP_SE         = 8'h20;
  localparam logic [7:0]  OP_BE         = 8'hD8;
  localparam logic [7:0]  OP_HBE        = 8'h52;
  localparam logic [7:0]  OP_CE1        = 8'hC7;
  localparam logic [7:0]  OP_CE2        = 8'h60;
  localparam logic [7:0]  OP_DPD        = 8'hB9;
  localparam logic [7:0]  OP_RES        = 8'hAB;
  localparam logic [7:0]  OP_MID        = 8'h90;
  localparam logic [7:0]  OP_JID        = 8'h9F;
  localparam logic [2:0]  ADDR_BYTES    = 3'h3;
  localparam logic [2:0]  FAST_BYTES    = 3'h4;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam logic [2:0]  LAST_DUAL     = 3'h3;
  localparam logic [1:0]  JID_LAST      = 2'h2;
  localparam logic [11:0] REG_STATUS    = 12'h000;
  localparam logic [11:0] REG_CTRL      = 12'h004;
  localparam logic [11:0] REG_OPINFO    = 12'h008;
  localparam int          CTRL_DONE     = 0;

  typedef enum logic [2:0] {S_IDLE, S_OPC, S_ADDR, S_WSR, S_PGM, S_END, S_OUT, S_IGN} sfife_st_t;

  typedef struct packed {
    logic        cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, io0_s1, io0_s2, wp_s1, wp_s2;
    sfife_st_t   st;
    logic [2:0]  bitcnt;
    logic [7:0]  shin;
    logic [7:0]  opcode;
    logic [2:0]  bcnt;
    logic [2:0]  bneed;
    logic [23:0] addr;
    logic [7:0]  osh;
    logic [2:0]  ocnt;
    logic [1:0]  idx;
    logic        got;
    logic        status_lock_bit;
    logic [3:0]  bp;
    logic        write_enable_latch, busy, vol, dpd, nv_pend;
    logic [23:0] timer;
    logic [7:0]  wsr_data;
    logic        so, so_oe, io0_o, io0_oe;
    logic        pgm_vld;
    logic [7:0]  pgm_data;
    logic [23:0] pgm_addr;
    logic        op_vld;
    logic [7:0]  op_code;
    logic [23:0] op_addr;
    logic        pready, pslverr;
    logic [31:0] prdata;
  } sfife_state_t;
endpackage

// ==== sim/sfife_host.sv ====
// Purpose: spi host model driving select, clock and io0 of the front end
// Assumes: mode 0, clock idle low and still between frames, 125 ns period
// Notes:   released serial out shows the inverse of its last bit, released io0 the host's dq bit (its inverse in dual shifts), so stale data cannot pass
module sfife_host (
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_line,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  input  wire logic i_io0,
  input  wire logic i_io0_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic dq;
  logic drv;
  logic so_seen;
  assign o_line  = i_io0_oe ? i_io0 : (drv ? dq : ~dq);
  assign so_seen = i_so_oe ? i_so : ~i_so;
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    dq     = 1'b0;
    drv    = 1'b1;
  end
  task automatic sel();
    #40 o_cs_n <= 1'b0;
    #60;
  endtask
  // deselect only after the last fall, so writes end on a byte edge
  task automatic desel();
    #60 o_cs_n <= 1'b1;
    #100;
  endtask
  task automatic shift(input logic [7:0] b, input int n, input bit dual, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < (dual ? n / 2 : n); i++) begin
      drv <= !dual;
      dq  <= b[7 - i];
      #62.5 r = dual ? {r[5:0], so_seen, o_line} : {r[6:0], so_seen};
      o_sck <= 1'b1;
      #62.5 o_sck <= 1'b0;
    end
  endtask
endmodule

// ==== sim/sfife_tb_top.sv ====
// Purpose: self-checking bench of the flash front end
// Assumes: zero-wait apb, array byte returned from its address
// Notes:   t_W shortened to 4000 core cycles to keep the run short
module sfife_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TW = 40000;
  localparam logic [7:0] MFR = 8'hC1;  // arbitrary
  localparam logic [7:0] MTY = 8'h2D;  // arbitrary
  localparam logic [7:0] CAP = 8'h47;  // arbitrary
  localparam logic [7:0] DEV = 8'h6E;  // arbitrary
  logic clk = 0, rst = 1, cs_n, sck, line, wp_n = 1, so, so_oe, io0, io0_oe;
  logic [23:0] aa, pga, opa;
  logic [7:0] ad = 0, pgd, opc, rx[$], q[$];
  logic pv, ov, psel = 0, pen = 0, pwr = 0, prdy, perr;
  logic [11:0] pad = 0;
  logic [31:0] pwd = 0, prd, seed = 32'h4886, pq[$], r;
  int err_count, check_count, cyc, oe_cnt, op_cnt;
  sfife_host host (.o_cs_n(cs_n), .o_sck(sck), .o_line(line), .i_so(so), .i_so_oe(so_oe),
                   .i_io0(io0), .i_io0_oe(io0_oe));
  sfife_top #(.TW_NS(TW), .MFR_ID(MFR), .MEM_TYPE(MTY), .CAPACITY(CAP), .DEV_ID(DEV)) dut (
    .i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_cs_n(cs_n), .i_sck(sck), .i_serial_io0(line),
    .i_wp_n(wp_n), .o_serial_out(so), .o_serial_out_oe(so_oe), .o_serial_io0(io0),
    .o_serial_io0_oe(io0_oe), .o_arr_addr(aa), .i_arr_data(ad), .o_pgm_vld(pv), .o_pgm_data(pgd),
    .o_pgm_addr(pga), .o_op_vld(ov), .o_op_code(opc), .o_op_addr(opa), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pad), .i_pwdata(pwd), .o_pready(prdy),
    .o_prdata(prd), .o_pslverr(perr));
  always #5 clk = ~clk;
  function automatic logic [7:0] af(logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    ad <= af(aa);
    cyc++;
    if (so_oe !== 1'b0 || io0_oe !== 1'b0) oe_cnt++;
    if (pv !== 1'b0) pq.push_back({pga, pgd});
    if (ov !== 1'b0) op_cnt++;
    if (cyc == 90000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rx(input logic [7:0] e[$]);
    foreach (e[i]) chk_w({24'h0, rx[i]}, {24'h0, e[i]});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, output logic [31:0] d, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pad  <= a;
    pwd  <= 32'h1;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    d = prd;
    er = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic chk_st(input logic [7:0] e, input logic [7:0] m = 8'hFF);
    logic er;
    apb(1'b0, sfife_pkg::REG_STATUS, r, er);
    chk_w({24'h0, r[7:0] & m}, {24'h0, e});
  endtask
  task automatic done_op();
    logic er;
    apb(1'b1, sfife_pkg::REG_CTRL, r, er);
  endtask
  // nb cuts the final byte short, to end a frame mid-byte
  task automatic cmd(input logic [7:0] t[$], input int nrd = 0, input bit dual = 0, input int nb = 8);
    logic [7:0] b;
    rx.delete();
    oe_cnt = 0;
    host.sel();
    foreach (t[i]) host.shift(t[i], (i == t.size() - 1 && nrd == 0) ? nb : 8, 1'b0, b);
    for (int i = 0; i < nrd; i++) begin
      host.shift(rnd(), (i == nrd - 1) ? nb : 8, dual, b);
      rx.push_back(b);
    end
    host.desel();
  endtask
  task automatic wsr(input logic [7:0] pre, input logic [7:0] d);
    cmd('{pre});
    cmd('{sfife_pkg::OP_WRSR, d});
  endtask
  logic [23:0] a;
  logic [7:0] op3[3] = '{sfife_pkg::OP_READ, sfife_pkg::OP_FAST, sfife_pkg::OP_DUAL};
  logic [7:0] er5[5] = '{sfife_pkg::OP_SE, sfife_pkg::OP_BE, sfife_pkg::OP_HBE, sfife_pkg::OP_CE1,
                         sfife_pkg::OP_CE2};
  logic e1;
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk_st(8'h00);
    apb(1'b0, 12'h00C, r, e1);
    chk_w({r[30:0], e1}, 32'h1);
    cmd('{sfife_pkg::OP_JID}, 4);
    chk_rx('{MFR, MTY, CAP, MFR});
    cmd('{sfife_pkg::OP_MID, rnd(), rnd(), 8'h00}, 3);
    chk_rx('{MFR, DEV, MFR});
    cmd('{sfife_pkg::OP_RES, rnd(), rnd(), rnd()}, 2);
    chk_rx('{DEV, DEV});
    cmd('{sfife_pkg::OP_WREN});
    cmd('{sfife_pkg::OP_RDSR}, 2);
    chk_rx('{8'h02, 8'h02});
    cmd('{sfife_pkg::OP_WRDI});
    cmd('{sfife_pkg::OP_RDSR}, 1);
    chk_rx('{8'h00});
    foreach (q[i]) q.delete(i);
    cmd('{8'hFF, 8'h00});
    chk_w(oe_cnt, 0);
    cmd('{8'h77, 8'h00});
    chk_w(oe_cnt, 0);
    chk_st(8'h00);
    wsr(sfife_pkg::OP_VWREN, 8'hFF);
    chk_st(8'hBC);
    wp_n <= 1'b0;
    wsr(sfife_pkg::OP_WREN, 8'h00);
    chk_st(8'hBC, 8'hFD);
    wp_n <= 1'b1;
    wsr(sfife_pkg::OP_VWREN, 8'h00);
    wp_n <= 1'b0;
    wsr(sfife_pkg::OP_VWREN, 8'h0C);
    chk_st(8'h0C, 8'hFD);
    wp_n <= 1'b1;
    cmd('{sfife_pkg::OP_WREN});
    cmd('{sfife_pkg::OP_WRSR, 8'h30}, 0, 0, 5);
    chk_st(8'h0E);
    cmd('{sfife_pkg::OP_WRSR, 8'h30});
    cmd('{sfife_pkg::OP_RDSR}, 1);
    chk_rx('{8'h33});
    cmd('{sfife_pkg::OP_READ, rnd(), rnd(), rnd()}, 1);
    chk_w(oe_cnt, 0);
    cmd('{sfife_pkg::OP_JID}, 1);
    chk_w(oe_cnt, 0);
    chk_st(8'h33);
    for (int i = 0; i < 2000 && r[0] !== 1'b0; i++) apb(1'b0, sfife_pkg::REG_STATUS, r, e1);
    chk_st(8'h30);
    cmd('{sfife_pkg::OP_WRSR, 8'h00});
    chk_st(8'h30);
    wsr(sfife_pkg::OP_VWREN, 8'h00);
    for (int k = 0; k < 6; k++) begin
      a = (k < 3) ? 24'(rnd()) : 24'h0000FF;
      q = '{op3[k % 3], a[23:16], a[15:8], a[7:0]};
      if (k % 3 != 0) q.push_back(rnd());
      cmd(q, 2, k % 3 == 2);
      chk_rx('{af(a), af(a + 24'h1)});
      cmd(q, 1, k % 3 == 2, 4);
      chk_st(8'h00);
    end
    a = {16'(rnd()), 8'hFE};
    q = '{sfife_pkg::OP_PP, a[23:16], a[15:8], a[7:0], rnd(), rnd(), rnd()};
    pq.delete();
    cmd('{sfife_pkg::OP_WREN});
    op_cnt = 0;
    cmd(q);
    chk_w(pq.size(), 3);
    for (int i = 0; i < 3; i++) chk_w(pq[i], {a[23:8], 8'hFE + 8'(i), q[4 + i]});
    chk_w({op_cnt[7:0], opc, opa[15:0]}, {8'h1, sfife_pkg::OP_PP, a[15:0]});
    chk_st(8'h03);
    done_op();
    chk_st(8'h00);
    foreach (er5[k]) begin
      a = 24'(rnd());
      q = '{er5[k]};
      if (k < 3) q = {q, a[23:16], a[15:8], a[7:0]};
      cmd('{sfife_pkg::OP_WREN});
      op_cnt = 0;
      cmd(q);
      chk_w({op_cnt[7:0], opc, opa[15:0]}, {8'h1, er5[k], (k < 3) ? a[15:0] : 16'h0});
      chk_st(8'h03);
      done_op();
    end
    op_cnt = 0;
    cmd('{sfife_pkg::OP_SE, a[23:16], a[15:8], a[7:0]});
    cmd('{sfife_pkg::OP_WREN});
    cmd('{sfife_pkg::OP_CE2}, 0, 0, 6);
    chk_w(op_cnt, 0);
    cmd('{sfife_pkg::OP_WRDI});
    cmd('{sfife_pkg::OP_DPD});
    cmd('{sfife_pkg::OP_RDSR}, 1);
    chk_w(oe_cnt, 0);
    cmd('{sfife_pkg::OP_RES, rnd(), rnd(), rnd()}, 1);
    chk_rx('{DEV});
    cmd('{sfife_pkg::OP_RDSR}, 1);
    chk_rx('{8'h00});
    final_report();
  end
endmodule
